// file: src/dpd_top.sv
`timescale 1ns/1ns
`include "dpd_defs.svh"
// Behaviour
// - Count rate is clock over 2(x+1)
// - One shared modulo-255 counter
// - Output high once counter exceeds threshold
// - Threshold zero gives always high
// - Threshold all ones gives always low
// - High fraction is (254-y)/255 for y from 01H to FEH
// - Master bit 7 runs divider and counter
// - Control bit 1 enables output A
// - Control bit 0 enables output B
// - Prescaler register at DAH
// - Duty registers at DBH and DCH
module dpd_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    output logic pwm_out_a,
    output logic pwm_out_b
);
    typedef struct packed {
        dpd_pkg::dpd_regs_t regs;
        dpd_pkg::dpd_state_t state;
        logic [7:0] count;
        logic out_a;
        logic out_b;
        logic [7:0] rdata;
    } dpd_top_state_t;

    dpd_top_state_t s_q;
    dpd_top_state_t s_d;
    dpd_tick_if tk ();
    logic tick;

    function automatic logic hit_addr(input logic [7:0] a);
        hit_addr = (a == `DPD_ADDR_PRESCALE) || (a == `DPD_ADDR_DUTY_A)
            || (a == `DPD_ADDR_DUTY_B) || (a == `DPD_ADDR_CONTROL);
    endfunction : hit_addr

    // Level of one output for a counter value and threshold
    function automatic logic pwm_level(input logic [7:0] cnt, input logic [7:0] thr);
        pwm_level = (cnt > thr);
    endfunction : pwm_level

    assign tk.run = s_q.regs.modulator_master_on;
    assign tk.prescale_value = s_q.regs.prescale_value;
    assign tick = tk.tick;

    dpd_prescaler u_pre (
        .clk(clk),
        .rst_b(rst_b),
        .tk(tk)
    );

    always_comb begin
        s_d = s_q;
        if (sfr_wr) begin
            case (sfr_addr)
                `DPD_ADDR_PRESCALE: begin
                    s_d.regs.prescale_value = sfr_wdata;
                end
                `DPD_ADDR_DUTY_A: begin
                    s_d.regs.duty_threshold_a = sfr_wdata;
                end
                `DPD_ADDR_DUTY_B: begin
                    s_d.regs.duty_threshold_b = sfr_wdata;
                end
                `DPD_ADDR_CONTROL: begin
                    s_d.regs.modulator_master_on = sfr_wdata[`DPD_BIT_MASTER_ON];
                    s_d.regs.output_a_enable = sfr_wdata[`DPD_BIT_OUT_A_EN];
                    s_d.regs.output_b_enable = sfr_wdata[`DPD_BIT_OUT_B_EN];
                end
                default: begin
                    s_d.regs = s_q.regs;
                end
            endcase
        end
        s_d.rdata = 8'h00;
        if (sfr_rd) begin
            case (sfr_addr)
                `DPD_ADDR_PRESCALE: s_d.rdata = s_q.regs.prescale_value;
                `DPD_ADDR_DUTY_A: s_d.rdata = s_q.regs.duty_threshold_a;
                `DPD_ADDR_DUTY_B: s_d.rdata = s_q.regs.duty_threshold_b;
                `DPD_ADDR_CONTROL: begin
                    s_d.rdata = 8'h00;
                    s_d.rdata[`DPD_BIT_MASTER_ON] = s_q.regs.modulator_master_on;
                    s_d.rdata[`DPD_BIT_OUT_A_EN] = s_q.regs.output_a_enable;
                    s_d.rdata[`DPD_BIT_OUT_B_EN] = s_q.regs.output_b_enable;
                end
                default: s_d.rdata = 8'h00;
            endcase
        end
        case (s_q.state)
            dpd_pkg::DPD_IDLE: begin
                s_d.count = 8'h00;
                s_d.out_a = 1'b0;
                s_d.out_b = 1'b0;
                if (s_q.regs.modulator_master_on) begin
                    s_d.state = dpd_pkg::DPD_RUN;
                end
            end
            dpd_pkg::DPD_RUN: begin
                if (!s_q.regs.modulator_master_on) begin
                    s_d.state = dpd_pkg::DPD_IDLE;
                    s_d.count = 8'h00;
                end else if (tick) begin
                    if (s_q.count == `DPD_COUNT_LAST) begin
                        s_d.count = 8'h00;
                    end else begin
                        s_d.count = s_q.count + 8'h01;
                    end
                end
                // Zero threshold: count 0 is not above, so full period needs
                // the level held across wrap; all ones never exceeded
                s_d.out_a = s_q.regs.output_a_enable
                    && (pwm_level(s_d.count, s_q.regs.duty_threshold_a)
                    || s_q.regs.duty_threshold_a == 8'h00);
                s_d.out_b = s_q.regs.output_b_enable
                    && (pwm_level(s_d.count, s_q.regs.duty_threshold_b)
                    || s_q.regs.duty_threshold_b == 8'h00);
                if (!s_q.regs.modulator_master_on) begin
                    s_d.out_a = 1'b0;
                    s_d.out_b = 1'b0;
                end
            end
            default: begin
                s_d.state = dpd_pkg::DPD_IDLE;
                s_d.count = 8'h00;
                s_d.out_a = 1'b0;
                s_d.out_b = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q.regs.prescale_value <= `DPD_RST_PRESCALE;
            s_q.regs.duty_threshold_a <= `DPD_RST_DUTY;
            s_q.regs.duty_threshold_b <= `DPD_RST_DUTY;
            s_q.regs.modulator_master_on <= 1'b0;
            s_q.regs.output_a_enable <= 1'b0;
            s_q.regs.output_b_enable <= 1'b0;
            s_q.state <= dpd_pkg::DPD_IDLE;
            s_q.count <= 8'h00;
            s_q.out_a <= 1'b0;
            s_q.out_b <= 1'b0;
            s_q.rdata <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata = s_q.rdata;
    assign sfr_hit = hit_addr(sfr_addr);
    assign pwm_out_a = s_q.out_a;
    assign pwm_out_b = s_q.out_b;

    a_count_range: assert property (@(posedge clk) disable iff (!rst_b)
        s_q.count <= `DPD_COUNT_LAST) else $error("counter beyond 254");
    a_count_wrap: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && s_q.state == dpd_pkg::DPD_RUN && s_q.regs.modulator_master_on
        && s_q.count == `DPD_COUNT_LAST) |=> s_q.count == 8'h00)
        else $error("counter did not wrap");
    a_idle_low: assert property (@(posedge clk) disable iff (!rst_b)
        !s_q.regs.modulator_master_on |=> ##1 (!pwm_out_a && !pwm_out_b))
        else $error("outputs not low when off");
    a_enable_a: assert property (@(posedge clk) disable iff (!rst_b)
        !s_q.regs.output_a_enable |=> !pwm_out_a) else $error("A drives while off");
    a_enable_b: assert property (@(posedge clk) disable iff (!rst_b)
        !s_q.regs.output_b_enable |=> !pwm_out_b) else $error("B drives while off");
    a_full_low: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.regs.duty_threshold_a == 8'hff) |=> !pwm_out_a)
        else $error("A high at FF");
    a_full_high: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.state == dpd_pkg::DPD_RUN && s_q.regs.modulator_master_on
        && s_q.regs.output_a_enable && s_q.regs.duty_threshold_a == 8'h00
        && $stable(s_q.regs)) |=> pwm_out_a) else $error("A low at 00");
    a_above_thr: assert property (@(posedge clk) disable iff (!rst_b)
        (pwm_out_b && s_q.regs.duty_threshold_b != 8'h00 && $stable(s_q.regs))
        |-> s_q.count > s_q.regs.duty_threshold_b) else $error("B high too early");
    a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_b)
        (sfr_rd && sfr_addr == `DPD_ADDR_CONTROL) |=> (sfr_rdata & ~`DPD_CONTROL_MASK) == 8'h00)
        else $error("unused control bits read set");
    a_tick_gap: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && s_q.regs.prescale_value == 8'h00 && $stable(s_q.regs)) |=> !tick)
        else $error("ticks closer than two cycles");

    // Register file: writes land next cycle, reads answer one cycle later
    a_wr_prescale: assert property (@(posedge clk) disable iff (!rst_b)
        (sfr_wr && sfr_addr == `DPD_ADDR_PRESCALE)
        |=> s_q.regs.prescale_value == $past(sfr_wdata)) else $error("prescale write lost");
    a_wr_duty_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sfr_wr && sfr_addr == `DPD_ADDR_DUTY_A)
        |=> s_q.regs.duty_threshold_a == $past(sfr_wdata)) else $error("duty A write lost");
    a_wr_duty_b: assert property (@(posedge clk) disable iff (!rst_b)
        (sfr_wr && sfr_addr == `DPD_ADDR_DUTY_B)
        |=> s_q.regs.duty_threshold_b == $past(sfr_wdata)) else $error("duty B write lost");
    a_wr_master: assert property (@(posedge clk) disable iff (!rst_b)
        (sfr_wr && sfr_addr == `DPD_ADDR_CONTROL) |=> s_q.regs.modulator_master_on
        == $past(sfr_wdata[`DPD_BIT_MASTER_ON])) else $error("master bit write lost");
    a_wr_en_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sfr_wr && sfr_addr == `DPD_ADDR_CONTROL) |=> s_q.regs.output_a_enable
        == $past(sfr_wdata[`DPD_BIT_OUT_A_EN])) else $error("enable A write lost");
    a_wr_en_b: assert property (@(posedge clk) disable iff (!rst_b)
        (sfr_wr && sfr_addr == `DPD_ADDR_CONTROL) |=> s_q.regs.output_b_enable
        == $past(sfr_wdata[`DPD_BIT_OUT_B_EN])) else $error("enable B write lost");
    a_rd_prescale: assert property (@(posedge clk) disable iff (!rst_b)
        (sfr_rd && sfr_addr == `DPD_ADDR_PRESCALE)
        |=> sfr_rdata == $past(s_q.regs.prescale_value)) else $error("prescale read wrong");
    a_rd_duty_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sfr_rd && sfr_addr == `DPD_ADDR_DUTY_A)
        |=> sfr_rdata == $past(s_q.regs.duty_threshold_a)) else $error("duty A read wrong");
    a_rd_duty_b: assert property (@(posedge clk) disable iff (!rst_b)
        (sfr_rd && sfr_addr == `DPD_ADDR_DUTY_B)
        |=> sfr_rdata == $past(s_q.regs.duty_threshold_b)) else $error("duty B read wrong");
    a_rd_idle: assert property (@(posedge clk) disable iff (!rst_b)
        !sfr_rd |=> sfr_rdata == 8'h00) else $error("read data not cleared");

    // Counter advances only on a tick and rests at zero when stopped
    a_count_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.state == dpd_pkg::DPD_RUN && s_q.regs.modulator_master_on && !tick)
        |=> $stable(s_q.count)) else $error("counter moved without tick");
    a_count_step: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.state == dpd_pkg::DPD_RUN && s_q.regs.modulator_master_on && tick
        && s_q.count != `DPD_COUNT_LAST) |=> s_q.count == $past(s_q.count) + 8'h01)
        else $error("counter did not step");
    a_idle_count: assert property (@(posedge clk) disable iff (!rst_b)
        s_q.state == dpd_pkg::DPD_IDLE |-> s_q.count == 8'h00)
        else $error("counter not zero while stopped");

    // Output levels against thresholds
    a_full_low_b: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.regs.duty_threshold_b == 8'hff) |=> !pwm_out_b) else $error("B high at FF");
    a_full_high_b: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.state == dpd_pkg::DPD_RUN && s_q.regs.modulator_master_on
        && s_q.regs.output_b_enable && s_q.regs.duty_threshold_b == 8'h00
        && $stable(s_q.regs)) |=> pwm_out_b) else $error("B low at 00");
    a_above_thr_a: assert property (@(posedge clk) disable iff (!rst_b)
        (pwm_out_a && s_q.regs.duty_threshold_a != 8'h00 && $stable(s_q.regs))
        |-> s_q.count > s_q.regs.duty_threshold_a) else $error("A high too early");
    a_below_thr_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!pwm_out_a && s_q.regs.output_a_enable && s_q.regs.modulator_master_on
        && s_q.regs.duty_threshold_a != 8'h00 && $stable(s_q.regs))
        |-> s_q.count <= s_q.regs.duty_threshold_a) else $error("A low too late");
    a_below_thr_b: assert property (@(posedge clk) disable iff (!rst_b)
        (!pwm_out_b && s_q.regs.output_b_enable && s_q.regs.modulator_master_on
        && s_q.regs.duty_threshold_b != 8'h00 && $stable(s_q.regs))
        |-> s_q.count <= s_q.regs.duty_threshold_b) else $error("B low too late");
endmodule : dpd_top

// file: src/dpd_defs.svh
`ifndef DPD_DEFS_SVH
`define DPD_DEFS_SVH

`define DPD_ADDR_PRESCALE 8'hda
`define DPD_ADDR_DUTY_A 8'hdb
`define DPD_ADDR_DUTY_B 8'hdc
`define DPD_ADDR_CONTROL 8'hfe
`define DPD_BIT_MASTER_ON 7
`define DPD_BIT_OUT_A_EN 1
`define DPD_BIT_OUT_B_EN 0
`define DPD_CONTROL_MASK 8'h83
`define DPD_RST_PRESCALE 8'h00
`define DPD_RST_DUTY 8'hff
`define DPD_RST_CONTROL 8'h00
`define DPD_COUNT_LAST 8'hfe

`endif

// file: src/dpd_pkg.sv
package dpd_pkg;
    typedef enum logic [1:0] {
        DPD_IDLE = 2'b01,
        DPD_RUN = 2'b10
    } dpd_state_t;

    typedef struct packed {
        logic [7:0] prescale_value;
        logic [7:0] duty_threshold_a;
        logic [7:0] duty_threshold_b;
        logic modulator_master_on;
        logic output_a_enable;
        logic output_b_enable;
    } dpd_regs_t;
endpackage : dpd_pkg

// file: src/dpd_tick_if.sv
`timescale 1ns/1ns
interface dpd_tick_if;
    logic run;
    logic [7:0] prescale_value;
    logic tick;
    modport ctrl (output run, output prescale_value, input tick);
    modport gen (input run, input prescale_value, output tick);
endinterface : dpd_tick_if

// file: src/dpd_prescaler.sv
`timescale 1ns/1ns
`include "dpd_defs.svh"
module dpd_prescaler (
    input wire logic clk,
    input wire logic rst_b,
    dpd_tick_if.gen tk
);
    typedef struct packed {
        logic [7:0] div;
        logic half;
    } dpd_pre_state_t;

    dpd_pre_state_t s_q;
    dpd_pre_state_t s_d;

    // Two stages: divide by x+1, then by two, giving 2(x+1)
    always_comb begin
        s_d = s_q;
        if (!tk.run) begin
            s_d.div = 8'h00;
            s_d.half = 1'b0;
        end else if (s_q.div == tk.prescale_value) begin
            s_d.div = 8'h00;
            s_d.half = ~s_q.half;
        end else begin
            s_d.div = s_q.div + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tk.tick = tk.run && s_q.half && (s_q.div == tk.prescale_value);
endmodule : dpd_prescaler

// file: verif/dpd_rc_filter.sv
`timescale 1ns/1ns
module dpd_rc_filter (
    input wire logic clk,
    input wire logic pwm_in,
    output real v_out
);
    // First-order low-pass, time constant of 64 clocks
    initial v_out = 0.0;
    always @(posedge clk) begin
        v_out <= v_out + ((pwm_in === 1'b1 ? 1.0 : 0.0) - v_out) / 64.0;
    end
endmodule : dpd_rc_filter

// file: verif/tb_dual_pwm_dac.sv
`timescale 1ns/1ns
`include "dpd_defs.svh"
module tb_dual_pwm_dac;
    logic clk, rst_b, sfr_wr, sfr_rd, rd_d, hit_d, sfr_hit, pwm_out_a, pwm_out_b;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [15:0] seed;
    logic [8:0] rd_q[$];
    int hi_q[$];
    int failures, n_tests, np;
    event go;
    real v_a, v_b;
    dpd_top u_dut (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b));
    dpd_rc_filter u_filt_a (.clk(clk), .pwm_in(pwm_out_a), .v_out(v_a));
    dpd_rc_filter u_filt_b (.clk(clk), .pwm_in(pwm_out_b), .v_out(v_b));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic int hi_exp(input logic [7:0] y, input logic en, input int step);
        if (en !== 1'b1 || y === 8'hff) return 0;
        if (y === 8'h00) return 255 * step;
        return (254 - int'(y)) * step;
    endfunction : hi_exp
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic hit, input logic [7:0] d);
        rd_q.push_back({hit, d});
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
    endtask : rd
    task automatic pwm(input logic [7:0] x, ya, yb, ctl);
        int step;
        int ea;
        int eb;
        step = 2 * (int'(x) + 1);
        ea = hi_exp(ya, ctl[7] & ctl[1], step);
        eb = hi_exp(yb, ctl[7] & ctl[0], step);
        wr(`DPD_ADDR_PRESCALE, x);
        wr(`DPD_ADDR_DUTY_A, ya);
        wr(`DPD_ADDR_DUTY_B, yb);
        wr(`DPD_ADDR_CONTROL, ctl);
        hi_q.push_back(ea);
        hi_q.push_back(eb);
        // Let one full period pass so old settings have flushed out
        repeat (255 * step + 8) @(negedge clk);
        np = 255 * step;
        ->go;
        repeat (np + 2) @(negedge clk);
        // Filtered level settles to a rail when the output never toggles
        if (ea == 0) chk(v_a < 0.01, "filter a not at low rail");
        if (eb == 0) chk(v_b < 0.01, "filter b not at low rail");
        if (ea == 255 * step) chk(v_a > 0.99, "filter a not at high rail");
        if (eb == 255 * step) chk(v_b > 0.99, "filter b not at high rail");
        $display("pwm test x=%h a=%h b=%h ctl=%h done", x, ya, yb, ctl);
    endtask : pwm
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        rd_d <= sfr_rd;
        hit_d <= sfr_hit;
    end
    initial forever begin
        @(negedge clk);
        if (rd_d === 1'b1) chk({hit_d, sfr_rdata} === rd_q.pop_front(), "read data");
    end
    initial begin : mon_pwm
        int ca;
        int cb;
        forever begin
            @(go);
            ca = 0;
            cb = 0;
            repeat (np) begin
                @(negedge clk);
                ca += int'(pwm_out_a === 1'b1);
                cb += int'(pwm_out_b === 1'b1);
            end
            chk(ca == hi_q.pop_front(), "output a high time");
            chk(cb == hi_q.pop_front(), "output b high time");
        end
    end
    initial begin
        #(20 * 60000);
        failures++;
        finish_test;
    end
    initial begin
        {rst_b, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
        seed = 16'h76cb;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        rd(`DPD_ADDR_PRESCALE, 1'b1, `DPD_RST_PRESCALE);
        rd(`DPD_ADDR_DUTY_A, 1'b1, `DPD_RST_DUTY);
        rd(`DPD_ADDR_DUTY_B, 1'b1, `DPD_RST_DUTY);
        rd(`DPD_ADDR_CONTROL, 1'b1, `DPD_RST_CONTROL);
        wr(`DPD_ADDR_PRESCALE, 8'ha5);
        rd(`DPD_ADDR_PRESCALE, 1'b1, 8'ha5);
        wr(`DPD_ADDR_CONTROL, 8'h7c);
        rd(`DPD_ADDR_CONTROL, 1'b1, 8'h00);
        rd(8'hdd, 1'b0, 8'h00);
        $display("register test done");
        pwm(8'h00, 8'h00, 8'hff, 8'h83);
        pwm(8'h01, 8'h01, 8'hfe, 8'h83);
        pwm(8'h00, 8'h80, 8'h40, 8'h82);
        pwm(8'h00, 8'h80, 8'h40, 8'h81);
        pwm(8'h00, 8'h00, 8'h00, 8'h03);
        repeat (3) begin
            seed = lfsr(seed);
            pwm({7'h00, seed[0]}, seed[15:8], seed[7:0], 8'h83);
        end
        finish_test;
    end
endmodule : tb_dual_pwm_dac
